// ---- src/operand_address_generator.sv ----
`timescale 1ns/1ps

module operand_address_generator
    import operand_addr_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // decode request
    input wire logic start_in,
    input wire logic [4:0] mode_in,
    input wire logic use_second_index_in,
    input wire logic rmw_in,
    input wire logic [7:0] first_index_in,
    input wire logic [7:0] second_index_in,
    input wire logic [15:0] next_pc_in,
    // memory read port
    input wire logic mem_ready_in,
    input wire logic [7:0] mem_data_in,
    output logic mem_read_out,
    output logic [15:0] mem_addr_out,
    // result
    output logic done_out,
    output logic illegal_out,
    output logic [1:0] operand_len_out,
    output logic [15:0] ea_out,
    output logic busy_out
);

    agen_state_t state_reg, state_next;
    addr_mode_t mode_reg;
    logic [15:0] fetch_ptr_reg;
    logic [7:0] imm_reg;
    logic [7:0] ptr_reg;
    logic [7:0] index_reg;
    logic [15:0] pc_reg;
    logic need_word, need_ptr, word_ptr, indexed, relative, mode_ok;
    logic word_ptr_reg, indexed_reg, need_word_reg, need_ptr_reg, relative_reg;
    logic [1:0] len_next;
    logic [15:0] ea_next;

    // per-mode decode of the operand field shape
    always_comb
    begin
        need_word = 1'b0;
        need_ptr = 1'b0;
        word_ptr = 1'b0;
        indexed = 1'b0;
        relative = 1'b0;
        len_next = len_none;
        case (addr_mode_t'(mode_in))
            mode_inherent: len_next = len_none;
            mode_immediate: len_next = len_one;
            mode_short_direct, mode_bit_direct: len_next = len_one;
            mode_long_direct:
            begin
                need_word = 1'b1;
                len_next = len_two;
            end
            mode_noofs_indexed: indexed = 1'b1;
            mode_short_indexed:
            begin
                indexed = 1'b1;
                len_next = len_one;
            end
            mode_long_indexed:
            begin
                indexed = 1'b1;
                need_word = 1'b1;
                len_next = len_two;
            end
            mode_short_indirect, mode_bit_indirect:
            begin
                need_ptr = 1'b1;
                len_next = len_one;
            end
            mode_long_indirect:
            begin
                need_ptr = 1'b1;
                word_ptr = 1'b1;
                len_next = len_one;
            end
            mode_short_ind_indexed:
            begin
                need_ptr = 1'b1;
                indexed = 1'b1;
                len_next = len_one;
            end
            mode_long_ind_indexed:
            begin
                need_ptr = 1'b1;
                word_ptr = 1'b1;
                indexed = 1'b1;
                len_next = len_one;
            end
            mode_rel_direct:
            begin
                relative = 1'b1;
                len_next = len_one;
            end
            mode_rel_indirect:
            begin
                relative = 1'b1;
                need_ptr = 1'b1;
                len_next = len_one;
            end
            mode_bit_direct_rel: len_next = len_two;
            mode_bit_indirect_rel:
            begin
                need_ptr = 1'b1;
                len_next = len_two;
            end
            default: len_next = len_none;
        endcase
        // second index prefix byte
        if (indexed && use_second_index_in)
        begin
            len_next = len_next + len_one;
        end
    end

    // read-modify-write refused with long sub-modes; unknown codes refused
    assign mode_ok = (mode_in < mode_count) &&
        !(rmw_in && (need_word || word_ptr));

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_reg <= st_idle;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            st_idle:
            begin
                if (start_in && mode_ok)
                begin
                    if (mode_in == mode_inherent || mode_in == mode_immediate
                        || mode_in == mode_noofs_indexed)
                    begin
                        state_next = st_done;
                    end
                    else
                    begin
                        state_next = st_fetch_hi;
                    end
                end
            end
            st_fetch_hi:
            begin
                if (mem_ready_in)
                begin
                    state_next = need_word_reg ? st_fetch_lo :
                        (need_ptr_reg ? st_ptr_hi : st_done);
                end
            end
            st_fetch_lo, st_ptr_lo:
            begin
                if (mem_ready_in)
                begin
                    state_next = st_done;
                end
            end
            st_ptr_hi:
            begin
                if (mem_ready_in)
                begin
                    state_next = word_ptr_reg ? st_ptr_lo : st_done;
                end
            end
            default: state_next = st_idle;
        endcase
    end

    // request capture
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            mode_reg <= mode_inherent;
            index_reg <= 8'h00;
            pc_reg <= 16'h0000;
            word_ptr_reg <= 1'b0;
            indexed_reg <= 1'b0;
            need_word_reg <= 1'b0;
            need_ptr_reg <= 1'b0;
            relative_reg <= 1'b0;
            operand_len_out <= len_none;
        end
        else if (state_reg == st_idle && start_in && mode_ok)
        begin
            mode_reg <= addr_mode_t'(mode_in);
            index_reg <= use_second_index_in ? second_index_in : first_index_in;
            pc_reg <= next_pc_in + {14'h0000, len_next};
            word_ptr_reg <= word_ptr;
            indexed_reg <= indexed;
            need_word_reg <= need_word;
            need_ptr_reg <= need_ptr;
            relative_reg <= relative;
            operand_len_out <= len_next;
        end
    end

    // operand field and pointer bytes, high byte of a word first
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            imm_reg <= 8'h00;
            ptr_reg <= 8'h00;
        end
        else if (mem_ready_in)
        begin
            case (state_reg)
                st_fetch_hi: imm_reg <= mem_data_in;
                st_ptr_hi: ptr_reg <= mem_data_in;
                default: ptr_reg <= ptr_reg;
            endcase
        end
    end

    // effective address; wider sums wrap in 16 bits, matching a 64K space
    always_comb
    begin
        logic [15:0] base;
        // last byte ends the walk, so it comes off the bus, not a register
        base[7:0] = mem_data_in;
        base[15:8] = (state_reg == st_fetch_lo) ? imm_reg
            : ((state_reg == st_ptr_lo) ? ptr_reg : 8'h00);
        if (relative_reg)
        begin
            ea_next = pc_reg + {{8{base[7]}}, base[7:0]};
        end
        else if (indexed_reg)
        begin
            ea_next = base + {8'h00, index_reg};
        end
        else
        begin
            ea_next = base;
        end
    end

    // memory walk: operand bytes follow the opcode, pointer from page zero
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            fetch_ptr_reg <= 16'h0000;
            mem_read_out <= 1'b0;
            mem_addr_out <= 16'h0000;
        end
        else
        begin
            mem_read_out <= (state_next == st_fetch_hi) || (state_next == st_fetch_lo)
                || (state_next == st_ptr_hi) || (state_next == st_ptr_lo);
            if (state_reg == st_idle && start_in && mode_ok)
            begin
                fetch_ptr_reg <= next_pc_in;
                mem_addr_out <= next_pc_in;
            end
            else if (mem_ready_in && state_reg == st_fetch_hi)
            begin
                // pointer sits in page zero, byte-sized address
                mem_addr_out <= need_word_reg ? fetch_ptr_reg + 16'h0001
                    : {8'h00, mem_data_in};
            end
            else if (mem_ready_in && state_reg == st_ptr_hi)
            begin
                mem_addr_out <= (mem_addr_out + 16'h0001) & page_zero_top;
            end
        end
    end

    // outputs
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            done_out <= 1'b0;
            illegal_out <= 1'b0;
            ea_out <= 16'h0000;
            busy_out <= 1'b0;
        end
        else
        begin
            done_out <= (state_next == st_done);
            illegal_out <= (state_reg == st_idle) && start_in && !mode_ok;
            busy_out <= (state_next != st_idle);
            if (state_reg != st_idle && state_next == st_done)
            begin
                ea_out <= ea_next;
            end
            else if (state_reg == st_idle && state_next == st_done)
            begin
                ea_out <= indexed ? {8'h00,
                    (use_second_index_in ? second_index_in : first_index_in)}
                    : next_pc_in;
            end
        end
    end

    a_rmw_refused: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_reg == st_idle && start_in && rmw_in && mode_in == mode_long_direct)
        |=> illegal_out && !busy_out)
        else $error("long mode accepted for rmw");
    a_inherent_len: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_reg == st_idle && start_in && mode_in == mode_inherent)
        |=> done_out && operand_len_out == len_none)
        else $error("inherent length wrong");
    a_noofs_ea: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_reg == st_idle && start_in && mode_in == mode_noofs_indexed
        && !use_second_index_in)
        |=> done_out && ea_out == {8'h00, $past(first_index_in)})
        else $error("no-offset indexed address wrong");
    a_short_page: assert property (@(posedge clk_in) disable iff (rst_in)
        (done_out && mode_reg == mode_short_direct) |-> ea_out <= page_zero_top)
        else $error("short direct left page zero");
    a_short_idx: assert property (@(posedge clk_in) disable iff (rst_in)
        (done_out && mode_reg == mode_short_indexed) |-> ea_out <= 16'h01fe)
        else $error("short indexed beyond range");
    a_rel_range: assert property (@(posedge clk_in) disable iff (rst_in)
        (done_out && relative_reg) |->
        (ea_out - pc_reg <= 16'h007f) || (pc_reg - ea_out <= 16'h0080))
        else $error("relative target out of reach");
    a_rel_disp_mem: assert property (@(posedge clk_in) disable iff (rst_in)
        (done_out && mode_reg == mode_rel_indirect)
        |-> ea_out == pc_reg + {{8{ptr_reg[7]}}, ptr_reg})
        else $error("relative displacement not taken from memory");
    a_second_index: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_reg == st_idle && start_in && mode_in == mode_noofs_indexed
        && use_second_index_in) |=> operand_len_out == len_one)
        else $error("second index length wrong");
    a_ptr_fetch: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_reg == st_ptr_hi) |-> mem_read_out && mem_addr_out <= page_zero_top)
        else $error("pointer outside page zero");

endmodule : operand_address_generator

// ---- src/operand_addr_pkg.sv ----
package operand_addr_pkg;

    // addressing modes, seventeen of them in seven families
    typedef enum logic [4:0] {
        mode_inherent = 5'h00,
        mode_immediate = 5'h01,
        mode_short_direct = 5'h02,
        mode_long_direct = 5'h03,
        mode_noofs_indexed = 5'h04,
        mode_short_indexed = 5'h05,
        mode_long_indexed = 5'h06,
        mode_short_indirect = 5'h07,
        mode_long_indirect = 5'h08,
        mode_short_ind_indexed = 5'h09,
        mode_long_ind_indexed = 5'h0a,
        mode_rel_direct = 5'h0b,
        mode_rel_indirect = 5'h0c,
        mode_bit_direct = 5'h0d,
        mode_bit_indirect = 5'h0e,
        mode_bit_direct_rel = 5'h0f,
        mode_bit_indirect_rel = 5'h10
    } addr_mode_t;

    localparam logic [4:0] mode_count = 5'h11;

    // operand bytes after the opcode, per mode (index bit adds one more in indexed modes)
    localparam logic [1:0] len_none = 2'h0;
    localparam logic [1:0] len_one = 2'h1;
    localparam logic [1:0] len_two = 2'h2;
    localparam logic [1:0] len_three = 2'h3;

    localparam logic [15:0] page_zero_top = 16'h00ff;

    typedef enum logic [5:0] {
        st_idle = 6'b000001,
        st_fetch_hi = 6'b000010,
        st_fetch_lo = 6'b000100,
        st_ptr_hi = 6'b001000,
        st_ptr_lo = 6'b010000,
        st_done = 6'b100000
    } agen_state_t;

endpackage : operand_addr_pkg

// ---- tb/mem_model.sv ----
`timescale 1ns/1ps

module mem_model
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // setup from bench
    input wire logic [7:0] key_in,
    input wire logic [2:0] lat_in,
    // read port
    input wire logic mem_read_in,
    input wire logic [15:0] mem_addr_in,
    output logic mem_ready_out,
    output logic [7:0] mem_data_out
);
    logic [2:0] wait_reg;

    // contents are a keyed hash so the bench can predict every byte
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            wait_reg <= 3'h0;
            mem_ready_out <= 1'b0;
            mem_data_out <= 8'h00;
        end
        else if (mem_read_in && !mem_ready_out && wait_reg >= lat_in)
        begin
            wait_reg <= 3'h0;
            mem_ready_out <= 1'b1;
            mem_data_out <= mem_addr_in[7:0] ^ mem_addr_in[15:8] ^ key_in;
        end
        else
        begin
            // toggled data so a late sample never sees the old byte
            wait_reg <= mem_read_in ? wait_reg + 3'h1 : 3'h0;
            mem_ready_out <= 1'b0;
            mem_data_out <= ~mem_data_out;
        end
    end
endmodule : mem_model

// ---- tb/operand_address_generator_tb.sv ----
`timescale 1ns/1ps

module operand_address_generator_tb;
    import operand_addr_pkg::*;

`define CHK(what, exp, got) begin cmp_count++; if ((got) !== (exp)) begin bad_count++; \
    $display("[ERR] %s expected %h seen %h", what, exp, got); end end

    typedef struct {logic ill; logic [1:0] len; logic [15:0] ea; logic use_ea;} note_t;

    logic clk_in, rst_in, start_in, use_second_index_in, rmw_in;
    logic [4:0] mode_in;
    logic [7:0] first_index_in, second_index_in, mem_data_in, key;
    logic [15:0] next_pc_in, mem_addr_out, ea_out;
    logic mem_ready_in, mem_read_out, done_out, illegal_out, busy_out;
    logic [1:0] operand_len_out;
    logic [2:0] lat;
    int bad_count = 0;
    int cmp_count = 0;
    int sent = 0;
    int got = 0;
    note_t notes[$];
    note_t seen;
    logic [1:0] len_tab [17] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h0, 2'h1, 2'h2, 2'h1, 2'h1,
        2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2};

    operand_address_generator u_operand_address_generator (.clk_in(clk_in), .rst_in(rst_in),
        .start_in(start_in), .mode_in(mode_in), .use_second_index_in(use_second_index_in),
        .rmw_in(rmw_in), .first_index_in(first_index_in), .second_index_in(second_index_in),
        .next_pc_in(next_pc_in), .mem_ready_in(mem_ready_in), .mem_data_in(mem_data_in),
        .mem_read_out(mem_read_out), .mem_addr_out(mem_addr_out), .done_out(done_out),
        .illegal_out(illegal_out), .operand_len_out(operand_len_out), .ea_out(ea_out),
        .busy_out(busy_out));

    mem_model u_mem_model (.clk_in(clk_in), .rst_in(rst_in), .key_in(key), .lat_in(lat),
        .mem_read_in(mem_read_out), .mem_addr_in(mem_addr_out),
        .mem_ready_out(mem_ready_in), .mem_data_out(mem_data_in));

    initial
    begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    function automatic logic [7:0] mb(input logic [15:0] a, input logic [7:0] k);
        return a[7:0] ^ a[15:8] ^ k;
    endfunction : mb

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : results

    task automatic run(input logic [4:0] m, input logic sec, input logic rw, input logic [2:0] l);
        note_t n;
        logic [7:0] k, fi, si, ix, d, p;
        logic [15:0] np, w, wp;
        int i;
        k = 8'($urandom);
        fi = 8'($urandom);
        si = 8'($urandom);
        np = 16'($urandom);
        ix = sec ? si : fi;
        d = mb(np, k);
        w = {d, mb(np + 16'h0001, k)};
        p = mb({8'h00, d}, k);
        wp = {p, mb({8'h00, d + 8'h01}, k)};
        n.use_ea = 1'b1;
        n.ea = 16'h0000;
        n.ill = (m >= mode_count) || (rw && (m == 3 || m == 6 || m == 8 || m == 10));
        n.len = (m < mode_count) ? len_tab[m] : 2'h0;
        if (sec && (m == 4 || m == 5 || m == 6 || m == 9 || m == 10))
            n.len = n.len + 2'h1;
        case (m)
            5'h00: n.use_ea = 1'b0;
            5'h01: n.ea = np;
            5'h02, 5'h0d, 5'h0f: n.ea = {8'h00, d};
            5'h03: n.ea = w;
            5'h04: n.ea = {8'h00, ix};
            5'h05: n.ea = {8'h00, d} + {8'h00, ix};
            5'h06: n.ea = w + {8'h00, ix};
            5'h07, 5'h0e, 5'h10: n.ea = {8'h00, p};
            5'h08: n.ea = wp;
            5'h09: n.ea = {8'h00, p} + {8'h00, ix};
            5'h0a: n.ea = wp + {8'h00, ix};
            5'h0b: n.ea = np + 16'h0001 + {{8{d[7]}}, d};
            5'h0c: n.ea = np + 16'h0001 + {{8{p[7]}}, p};
            default: n.use_ea = 1'b0;
        endcase
        @(posedge clk_in);
        key <= k;
        lat <= l;
        first_index_in <= fi;
        second_index_in <= si;
        next_pc_in <= np;
        mode_in <= m;
        use_second_index_in <= sec;
        rmw_in <= rw;
        start_in <= 1'b1;
        notes.push_back(n);
        sent++;
        @(posedge clk_in);
        start_in <= 1'b0;
        for (i = 0; i < 100 && got != sent; i++)
            @(posedge clk_in);
        if (got != sent)
        begin
            bad_count++;
            $display("[ERR] result wait expected %0d seen %0d", sent, got);
            results();
        end
    endtask : run

    // results are judged mid-cycle, clear of the driving edge
    always @(negedge clk_in)
    begin
        if (done_out === 1'b1 || illegal_out === 1'b1)
        begin
            if (notes.size() == 0)
                `CHK("unexpected result", 1'b0, 1'b1)
            else
            begin
                seen = notes.pop_front();
                `CHK("illegal flag", seen.ill, illegal_out)
                `CHK("busy on refusal", 1'b0, busy_out & illegal_out)
                if (!seen.ill)
                    `CHK("operand length", seen.len, operand_len_out)
                if (!seen.ill && seen.use_ea)
                    `CHK("effective address", seen.ea, ea_out)
            end
            got++;
        end
    end

    initial
    begin
        rst_in = 1'b1;
        start_in = 1'b0;
        mode_in = 5'h00;
        use_second_index_in = 1'b0;
        rmw_in = 1'b0;
        first_index_in = 8'h00;
        second_index_in = 8'h00;
        next_pc_in = 16'h0000;
        key = 8'h00;
        lat = 3'h0;
        void'($urandom(39));
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        for (int m = 0; m < 17; m++)
            for (int s = 0; s < 2; s++)
                run(5'(m), s[0], 1'b0, 3'(s * 7));
        $display("test all modes done");
        for (int m = 0; m < 17; m++)
            run(5'(m), 1'($urandom), 1'b1, 3'h1);
        $display("test read-modify-write done");
        for (int m = 17; m < 32; m++)
            run(5'(m), 1'b0, 1'($urandom), 3'h0);
        $display("test illegal codes done");
        repeat (150)
            run(5'($urandom_range(0, 16)), 1'($urandom), 1'($urandom), 3'($urandom));
        $display("test random mix done");
        results();
    end
endmodule : operand_address_generator_tb
